//--- rtl/zqc_cal_odt.sv
// Impedance calibration command handling and termination gating
//
// How it works
// [R1] First long calibration gets the initial time, later ones the operational time.
// [R2] Short calibration window lasts 64 link clocks and corrects impedance error.
// [R3] At calibration end, results move into driver and termination codes.
// [R4] Controller may send a long calibration at any time.
// [R5] Controller keeps the channel quiet during any calibration window.
// [R6] Calibration current path switches off once calibration is achieved.
// [R7] Controller precharges all banks and waits before calibrating.
// [R8] No calibration after self refresh exit without an explicit command.
// [R9] Controller waits the self refresh exit delay before calibrating.
// [R10] Devices sharing a resistor never get overlapping calibration windows.
// [R11] Controller holds clock enable high throughout calibration.
// [R12] Termination is forced off by the device during the calibration window.
// [R13] All devices on the data bus stay high impedance during calibration.
// [R14] Termination stays off while in self refresh.
// [R15] Termination pin ignored when nominal select is zero or in self refresh.
// [R16] x8 strobe termination applies only when the strobe enable bit is set.
// [R17] A reset-cleared flag, set by the first long calibration, picks the time.
`timescale 1ns/1ps
`include "zqc_cfg.svh"
module zqc_cal_odt
  import zqc_pkg::*;
#(
  parameter logic [`ZQC_CNT_W-1:0] INIT_CAL_TIME_NCK = `ZQC_CNT_W'(`ZQC_INIT_CAL_TIME_NCK),
  parameter logic [`ZQC_CNT_W-1:0] OPER_CAL_TIME_NCK = `ZQC_CNT_W'(`ZQC_OPER_CAL_TIME_NCK),
  parameter logic [`ZQC_CNT_W-1:0] SHORT_CAL_TIME_NCK = `ZQC_CNT_W'(`ZQC_SHORT_CAL_TIME_NCK)
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic link_clk_in,
  input wire zqc_cmd_s cmd_in,
  input wire logic cke_in,
  input wire logic term_pin_in,
  input wire logic self_refresh_in,
  input wire logic [2:0] nom_term_sel_in,
  input wire logic strobe_term_en_in,
  input wire logic x8_mode_in,
  input wire logic engine_done_in,
  input wire zqc_code_s engine_result_in,
  output logic engine_start_out,
  output logic cal_current_en_out,
  output zqc_code_s cal_code_out,
  output logic cal_busy_out,
  output logic init_cal_done_out,
  output logic term_on_out,
  output logic strobe_term_on_out
);
  // One link clock per nCK, so cycle counts equal the times
  localparam logic [`ZQC_CNT_W-1:0] INIT_CAL_CYC = INIT_CAL_TIME_NCK;
  localparam logic [`ZQC_CNT_W-1:0] OPER_CAL_CYC = OPER_CAL_TIME_NCK;
  localparam logic [`ZQC_CNT_W-1:0] SHORT_CAL_CYC = SHORT_CAL_TIME_NCK;

  // ---- Link clock domain ----
  logic lnk_busy_reg;
  logic lnk_busy_next;
  logic [`ZQC_CNT_W-1:0] lnk_cnt_reg;
  logic [`ZQC_CNT_W-1:0] lnk_cnt_next;
  logic lnk_first_reg;
  logic lnk_first_next;
  logic lnk_start_tgl_reg;
  logic lnk_start_tgl_next;
  logic lnk_end_tgl_reg;
  logic lnk_end_tgl_next;
  logic cmd_take;
  logic lnk_done;
  logic [`ZQC_CNT_W-1:0] load_val;

  // Commands arriving inside a window are dropped
  assign cmd_take = cmd_in.valid && cke_in && !lnk_busy_reg; // R5 R8
  // Window length by command kind and first-long flag
  assign load_val = !cmd_in.long_cal ? SHORT_CAL_CYC : // R2
                    (lnk_first_reg ? OPER_CAL_CYC : INIT_CAL_CYC); // R1
  assign lnk_done = lnk_busy_reg && (lnk_cnt_reg == `ZQC_CNT_W'(1));
  assign lnk_busy_next = cmd_take || (lnk_busy_reg && !lnk_done);
  assign lnk_cnt_next = cmd_take ? load_val :
                        (lnk_busy_reg ? lnk_cnt_reg - `ZQC_CNT_W'(1) : lnk_cnt_reg);
  assign lnk_first_next = lnk_first_reg || (cmd_take && cmd_in.long_cal); // R17
  assign lnk_start_tgl_next = lnk_start_tgl_reg ^ cmd_take;
  assign lnk_end_tgl_next = lnk_end_tgl_reg ^ lnk_done;

  // Link-side window state
  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lnk_busy_reg <= 1'b0;
      lnk_cnt_reg <= '0;
      lnk_first_reg <= 1'b0;
      lnk_start_tgl_reg <= 1'b0;
      lnk_end_tgl_reg <= 1'b0;
    end else begin
      lnk_busy_reg <= lnk_busy_next;
      lnk_cnt_reg <= lnk_cnt_next;
      lnk_first_reg <= lnk_first_next;
      lnk_start_tgl_reg <= lnk_start_tgl_next;
      lnk_end_tgl_reg <= lnk_end_tgl_next;
    end
  end

  // ---- Crossing into the core clock ----
  logic [`ZQC_SYNC_W-1:0] sync_d;
  logic [`ZQC_SYNC_W-1:0] sync_q;

  assign sync_d = {lnk_first_reg, term_pin_in, lnk_end_tgl_reg, lnk_start_tgl_reg};

  zqc_sync #(
    .W(`ZQC_SYNC_W)
  ) i_zqc_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .d_in(sync_d),
    .q_out(sync_q)
  );

  // ---- Core clock domain ----
  zqc_state_e state_reg;
  zqc_state_e state_next;
  zqc_code_s res_reg;
  zqc_code_s res_next;
  zqc_code_s code_next;
  logic start_prev_reg;
  logic end_prev_reg;
  logic cal_win_next;
  logic start_edge;
  logic end_edge;
  logic cal_exit;
  logic engine_start_next;
  logic current_next;
  logic nom_enabled;
  logic term_next;
  logic strobe_next;

  // Toggle edges mark window start and end
  assign start_edge = sync_q[`ZQC_SYNC_START] ^ start_prev_reg;
  assign end_edge = sync_q[`ZQC_SYNC_END] ^ end_prev_reg;
  assign cal_exit = engine_done_in || end_edge;
  assign cal_win_next = start_edge || (cal_busy_out && !end_edge);

  // Calibration sequence
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ZQC_IDLE: begin
        if (start_edge) begin
          state_next = ZQC_CAL; // R8
        end
      end
      ZQC_CAL: begin
        if (cal_exit) begin
          state_next = ZQC_XFER;
        end
      end
      ZQC_XFER: begin
        state_next = ZQC_IDLE;
      end
      default: begin
        state_next = ZQC_IDLE;
      end
    endcase
  end

  // Engine control, result capture and transfer to the IO
  assign engine_start_next = (state_reg == ZQC_IDLE) && start_edge;
  assign current_next = (state_next == ZQC_CAL); // R6
  assign res_next = ((state_reg == ZQC_CAL) && cal_exit) ? engine_result_in : res_reg;
  assign code_next = (state_reg == ZQC_XFER) ? res_reg : cal_code_out; // R3

  // Termination gating; drops in the same cycle the window opens
  assign nom_enabled = (nom_term_sel_in != `ZQC_NOM_OFF);
  assign term_next = sync_q[`ZQC_SYNC_PIN] && nom_enabled // R15
                     && !self_refresh_in // R14 R15
                     && !cal_win_next; // R12
  assign strobe_next = term_next && x8_mode_in && strobe_term_en_in; // R16

  // Core state registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ZQC_IDLE;
      start_prev_reg <= 1'b0;
      end_prev_reg <= 1'b0;
      res_reg <= {`ZQC_CODE_RST, `ZQC_CODE_RST};
      cal_code_out <= {`ZQC_CODE_RST, `ZQC_CODE_RST};
      cal_busy_out <= 1'b0;
      engine_start_out <= 1'b0;
      cal_current_en_out <= 1'b0;
      init_cal_done_out <= 1'b0;
      term_on_out <= 1'b0;
      strobe_term_on_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      start_prev_reg <= sync_q[`ZQC_SYNC_START];
      end_prev_reg <= sync_q[`ZQC_SYNC_END];
      res_reg <= res_next;
      cal_code_out <= code_next;
      cal_busy_out <= cal_win_next;
      engine_start_out <= engine_start_next;
      cal_current_en_out <= current_next;
      init_cal_done_out <= sync_q[`ZQC_SYNC_FIRST];
      term_on_out <= term_next;
      strobe_term_on_out <= strobe_next;
    end
  end

  // ---- Checks, link domain ----
  first_long_a: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // R1
    cmd_take && cmd_in.long_cal && !lnk_first_reg |=> lnk_cnt_reg == INIT_CAL_CYC)
    else $error("first long window not initial time");
  later_long_a: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // R1
    cmd_take && cmd_in.long_cal && lnk_first_reg |=> lnk_cnt_reg == OPER_CAL_CYC)
    else $error("later long window not operational time");
  short_window_a: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // R2
    cmd_take && !cmd_in.long_cal |=> lnk_busy_reg && lnk_cnt_reg == SHORT_CAL_CYC)
    else $error("short window not loaded with short time");
  first_flag_a: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // R17
    cmd_take && cmd_in.long_cal |=> lnk_first_reg ##1 lnk_first_reg)
    else $error("first long flag not set and held");
  busy_drop_a: assert property (@(posedge link_clk_in) disable iff (!rst_n_in) // R5
    lnk_done |=> !lnk_busy_reg && $changed(lnk_end_tgl_reg))
    else $error("window did not close on count end");

  // ---- Checks, core domain ----
  term_cal_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R12
    cal_busy_out |-> !term_on_out && !strobe_term_on_out)
    else $error("termination on during calibration window");
  term_sr_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R14
    self_refresh_in |=> !term_on_out)
    else $error("termination on in self refresh");
  pin_ignored_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R15
    nom_term_sel_in == `ZQC_NOM_OFF |=> !term_on_out)
    else $error("termination pin not ignored with nominal off");
  strobe_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R16
    strobe_term_on_out |-> term_on_out && $past(x8_mode_in) && $past(strobe_term_en_in))
    else $error("strobe termination without x8 enable");
  code_update_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R3
    state_reg == ZQC_CAL && cal_exit |=> ##1 cal_code_out == $past(engine_result_in, 2))
    else $error("calibration result not transferred");
  current_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
    state_reg == ZQC_XFER |=> !cal_current_en_out)
    else $error("calibration current left on");
  no_self_cal_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
    !start_edge |=> !engine_start_out)
    else $error("engine started without a command");

  short_cal_c: cover property (@(posedge link_clk_in) disable iff (!rst_n_in)
    cmd_take && !cmd_in.long_cal);
  init_cal_c: cover property (@(posedge link_clk_in) disable iff (!rst_n_in)
    cmd_take && cmd_in.long_cal && !lnk_first_reg);
  oper_cal_c: cover property (@(posedge link_clk_in) disable iff (!rst_n_in)
    cmd_take && cmd_in.long_cal && lnk_first_reg);
  xfer_c: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    state_reg == ZQC_XFER);
  drop_c: cover property (@(posedge link_clk_in) disable iff (!rst_n_in)
    cmd_in.valid && lnk_busy_reg);
endmodule

//--- rtl/zqc_cfg.svh
// Constants for the calibration and termination gating block
`ifndef ZQC_CFG_SVH
`define ZQC_CFG_SVH
`define ZQC_CODE_W 6
`define ZQC_CNT_W 11
`define ZQC_INIT_CAL_TIME_NCK 1024
`define ZQC_OPER_CAL_TIME_NCK 512
`define ZQC_SHORT_CAL_TIME_NCK 64
`define ZQC_CODE_RST 6'h20
`define ZQC_NOM_OFF 3'h0
`define ZQC_SYNC_W 4
`define ZQC_SYNC_START 0
`define ZQC_SYNC_END 1
`define ZQC_SYNC_PIN 2
`define ZQC_SYNC_FIRST 3
`endif

//--- rtl/zqc_pkg.sv
// Types shared by the calibration and termination gating block
`include "zqc_cfg.svh"
package zqc_pkg;
  typedef enum logic [1:0] {
    ZQC_IDLE = 2'h0,
    ZQC_CAL = 2'h1,
    ZQC_XFER = 2'h3
  } zqc_state_e;

  typedef struct packed {
    logic [`ZQC_CODE_W-1:0] drv;
    logic [`ZQC_CODE_W-1:0] term;
  } zqc_code_s;

  typedef struct packed {
    logic valid;
    logic long_cal;
  } zqc_cmd_s;
endpackage

//--- rtl/zqc_sync.sv
// Two-flop synchroniser for a bundle of independent bits
`timescale 1ns/1ps
module zqc_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      q_out <= '0;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule

//--- tb/zqc_ctrl_model.sv
// Controller-side model issuing calibration commands on the link
`timescale 1ns/1ps
module zqc_ctrl_model
  import zqc_pkg::*;
(
  input wire logic link_clk_in,
  output zqc_cmd_s cmd_out,
  output logic cke_out
);
  // Idle command bus, clock enable high except while issue_no_cke runs
  initial begin
    cmd_out = '0;
    cke_out = 1'b1;
  end
  // One command for one link cycle; caller keeps the channel quiet
  task automatic issue(input logic lng);
    @(negedge link_clk_in);
    cmd_out = '{valid: 1'b1, long_cal: lng};
    @(negedge link_clk_in);
    cmd_out = '{valid: 1'b0, long_cal: ~lng};
  endtask
  // Command with clock enable low, which the device must drop
  task automatic issue_no_cke(input logic lng);
    @(negedge link_clk_in);
    cke_out = 1'b0;
    cmd_out = '{valid: 1'b1, long_cal: lng};
    @(negedge link_clk_in);
    cmd_out = '{valid: 1'b0, long_cal: ~lng};
    cke_out = 1'b1;
  endtask
endmodule

//--- tb/test_zqc_cal_odt.sv
// Self-checking bench for calibration and termination gating
`timescale 1ns/1ps
module test_zqc_cal_odt
  import zqc_pkg::*;
;
  logic clk_in = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n_in = 1'b0;
  logic term_pin, self_ref, strobe_en, x8, eng_done, cke;
  logic eng_start, cur_en, busy, init_done, term_on, strobe_on;
  logic [2:0] nom_sel;
  zqc_code_s eng_res, code;
  zqc_cmd_s cmd;
  int bad_count = 0;
  int compares = 0;

  // Core clock and unrelated link clock
  always #2.5 clk_in = ~clk_in;
  initial begin
    #1.3;
    forever #24 link_clk = ~link_clk;
  end

  zqc_ctrl_model i_zqc_ctrl_model (.link_clk_in(link_clk), .cmd_out(cmd), .cke_out(cke));

  zqc_cal_odt #(.INIT_CAL_TIME_NCK(11'h010), .OPER_CAL_TIME_NCK(11'h008),
    .SHORT_CAL_TIME_NCK(11'h004)) i_zqc_cal_odt (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk), .cmd_in(cmd),
    .cke_in(cke), .term_pin_in(term_pin), .self_refresh_in(self_ref),
    .nom_term_sel_in(nom_sel), .strobe_term_en_in(strobe_en), .x8_mode_in(x8),
    .engine_done_in(eng_done), .engine_result_in(eng_res),
    .engine_start_out(eng_start), .cal_current_en_out(cur_en), .cal_code_out(code),
    .cal_busy_out(busy), .init_cal_done_out(init_done), .term_on_out(term_on),
    .strobe_term_on_out(strobe_on));

  // Compare tasks and verdict
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Set termination inputs, then check both termination outputs
  task automatic term_case(input logic pin, sr, xm, se, input logic [2:0] nom,
    input logic [1:0] exp);
    @(negedge clk_in);
    term_pin = pin;
    self_ref = sr;
    x8 = xm;
    strobe_en = se;
    nom_sel = nom;
    repeat (4) @(negedge clk_in);
    chk("term", {10'h000, exp}, {10'h000, term_on, strobe_on});
  endtask

  // One calibration window; engine answers early or not at all; dup sends a refused command
  task automatic cal_run(input logic lng, early, dup, input zqc_code_s res, input int lo, hi);
    int len, starts, t_on;
    len = 0;
    starts = 0;
    t_on = 0;
    eng_res = res;
    fork
      begin
        i_zqc_ctrl_model.issue(lng);
        if (dup) i_zqc_ctrl_model.issue(~lng);
      end
    join_none
    for (int i = 0; i < 400; i++) begin
      @(negedge clk_in);
      if (busy === 1'b1) len++;
      if (eng_start === 1'b1) starts++;
      if (busy === 1'b1 && term_on !== 1'b0) t_on++;
      eng_done = early && (len == 10);
      if (len == 5) chk("cur_on", 12'h001, {11'h000, cur_en});
      if (early && len == 20) chk("code_early", res, code);
      if (early && len == 20) chk("cur_off", 12'h000, {11'h000, cur_en});
      if (len > 0 && busy === 1'b0) break;
    end
    // Code settles one core cycle after the window closes; current drops as it closes
    repeat (2) @(negedge clk_in);
    chk_rng("window", lo, hi, len);
    chk_rng("starts", 1, 1, starts);
    chk_rng("term_busy", 0, 0, t_on);
    chk("code", res, code);
    chk("cur_end", 12'h000, {11'h000, cur_en});
  endtask

  // Main sequence
  initial begin
    term_pin = 1'b0;
    self_ref = 1'b0;
    strobe_en = 1'b0;
    x8 = 1'b0;
    eng_done = 1'b0;
    nom_sel = 3'h0;
    eng_res = '0;
    repeat (4) @(negedge clk_in);
    repeat (2) @(posedge link_clk);
    @(negedge clk_in);
    rst_n_in = 1'b1;
    chk("code_rst", 12'h820, code);
    chk("flag_rst", 12'h000, {9'h000, init_done, busy, cur_en});
    term_case(1'b1, 1'b0, 1'b1, 1'b1, 3'h1, 2'b11);
    term_case(1'b1, 1'b0, 1'b1, 1'b0, 3'h1, 2'b10);
    term_case(1'b1, 1'b0, 1'b0, 1'b1, 3'h1, 2'b10);
    term_case(1'b1, 1'b0, 1'b1, 1'b1, 3'h0, 2'b00);
    term_case(1'b1, 1'b1, 1'b1, 1'b1, 3'h1, 2'b00);
    term_case(1'b0, 1'b0, 1'b1, 1'b1, 3'h7, 2'b00);
    term_case(1'b1, 1'b0, 1'b1, 1'b1, 3'h7, 2'b11);
    repeat (40) @(negedge clk_in);
    chk("sr_exit", 12'h000, {10'h000, busy, cur_en});
    i_zqc_ctrl_model.issue_no_cke(1'b1);
    repeat (20) @(negedge clk_in);
    chk("cke_drop", 12'h000, {10'h000, busy, init_done});
    cal_run(1'b1, 1'b1, 1'b0, 12'hA5C, 150, 158);
    chk("first_done", 12'h001, {11'h000, init_done});
    cal_run(1'b1, 1'b0, 1'b0, 12'h3C3, 73, 81);
    cal_run(1'b0, 1'b0, 1'b1, 12'h1E7, 35, 42);
    cal_run(1'b0, 1'b1, 1'b0, 12'h5A6, 35, 42);
    end_of_test;
  end

  // Watchdog against a hung handshake
  initial begin
    #20000;
    bad_count++;
    end_of_test;
  end
endmodule
